// *** logic/ctsf_params.svh ***
// timing and lamp constants for the charge timer and status state machine
// assumes the oscillator tick enable and the 200 MHz system clock described below
`ifndef CTSF_PARAMS_SVH
`define CTSF_PARAMS_SVH
`define CTSF_CLK_MHZ 200
`define CTSF_TO_MIN_PER_NF 14
`define CTSF_TO_OSC_CYCLES 32'd4096
`define CTSF_TRICKLE_DIV 3
`define CTSF_TRICKLE_MIN_CYC 16'h000f
`define CTSF_EOC_QUAL_CYC 3'h3
`define CTSF_LAMP_STEP_MS 500
`define CTSF_LAMP_STEP_CLKS (`CTSF_LAMP_STEP_MS * 1000 * `CTSF_CLK_MHZ)
`define CTSF_FLASH_HALF_MS 500
`define CTSF_FLASH_HALF_CLKS (`CTSF_FLASH_HALF_MS * 1000 * `CTSF_CLK_MHZ)
`endif

// *** logic/ctsf_pkg.sv ***
// types shared by the charge state machine files
// assumes nothing beyond a SystemVerilog compiler
package ctsf_pkg;
    typedef enum logic [2:0] {
        CTSF_LAMP_SEQ = 3'h0,
        CTSF_IDLE = 3'h1,
        CTSF_TRICKLE = 3'h2,
        CTSF_FAST = 3'h3,
        CTSF_TOPOFF = 3'h4,
        CTSF_DONE_OFF = 3'h5,
        CTSF_LATCH_OFF = 3'h6,
        CTSF_FAULT = 3'h7
    } ctsf_state_t;
endpackage : ctsf_pkg

// *** logic/ctsf_sync.sv ***
// three stage synchroniser for one asynchronous level
// assumes a single clock; output changes only when stages two and three agree
`timescale 1ns/100ps
module ctsf_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in and out
    input wire logic d,
    output logic q
);
    logic s1, s2, s3;
    logic next_q;

    // only s2 and s3 are compared; s1 feeds s2 alone
    always_comb begin
        next_q = (s2 == s3) ? s3 : q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule : ctsf_sync

// *** logic/ctsf_top.sv ***
// charge timer and status state machine of a single cell charger
// assumes OSC_TICK is a one-cycle pulse per oscillator period; comparator pins are asynchronous
// How it works
// - timeout spans a parameter count of oscillator ticks, 14 min per nF.
// - timeout expiry turns the lamp green (end of charge) always.
// - expiry above 4.05V keeps charging in top-off until the restarted timeout expires again.
// - expiry below 4.05V shows green, charger off, held until enable toggles.
// - trickle longer than one eighth timeout latches fault, charger off, flashing.
// - trickle lasts at least 15 oscillator ticks before fast charge.
// - end of charge restarts timeout; its expiry turns charger off.
// - below recharge threshold after the top-off shutdown restarts charging, lamp stays green.
// - after reset lamp shows red, green, yellow, off, 500ms each.
// - while charging before end of charge only the charging lamp sink pulls low.
// - proper finish releases charging sink and pulls the done sink low.
// - green persists through recharge until reset, fault or loss of enable.
// - temperature fault during trickle, fast or top-off gives steady yellow and clears itself.
// - other faults flash yellow at 1Hz, latched until enable toggles.
// - low current below recharge threshold never counts as end of charge.
// - end of charge needs high voltage and low current for 3 ticks.
`timescale 1ns/100ps
`include "ctsf_params.svh"
module ctsf_top #(
    parameter logic [31:0] TO_CYC = `CTSF_TO_OSC_CYCLES,
    parameter int LAMP_CLKS = `CTSF_LAMP_STEP_CLKS,
    parameter int FLASH_CLKS = `CTSF_FLASH_HALF_CLKS
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // oscillator tick and enable
    input wire logic OSC_TICK,
    input wire logic EN_N,
    // comparator inputs
    input wire logic VBAT_ABOVE_TRICKLE,
    input wire logic VBAT_ABOVE_RECHG,
    input wire logic VBAT_ABOVE_405,
    input wire logic ISEN_BELOW_TERM,
    input wire logic TEMP_OK,
    input wire logic SHORT_FAULT,
    // outputs
    output logic CHARGER_ON,
    output logic TRICKLE_MODE,
    output logic CHG_LAMP_SINK_O,
    output logic CHG_LAMP_SINK_OE,
    output logic DONE_LAMP_SINK_O,
    output logic DONE_LAMP_SINK_OE
);
    import ctsf_pkg::*;

    logic en_s, vtr_s, vrc_s, v405_s, ilow_s, tok_s, sc_s;
    ctsf_state_t state, next_state;
    logic [31:0] to_cnt, next_to_cnt;
    logic [2:0] eoc_cnt, next_eoc_cnt;
    logic green, next_green;
    logic [1:0] lamp_step, next_lamp_step;
    logic [31:0] lamp_cnt, next_lamp_cnt;
    logic [31:0] fl_cnt, next_fl_cnt;
    logic flash, next_flash;
    logic chg_led, done_led;

    // all comparator inputs and the enable pass the synchroniser
    ctsf_sync u_en (.clk(CLK), .rst(RST), .d(~EN_N), .q(en_s));
    ctsf_sync u_vtr (.clk(CLK), .rst(RST), .d(VBAT_ABOVE_TRICKLE), .q(vtr_s));
    ctsf_sync u_vrc (.clk(CLK), .rst(RST), .d(VBAT_ABOVE_RECHG), .q(vrc_s));
    ctsf_sync u_v405 (.clk(CLK), .rst(RST), .d(VBAT_ABOVE_405), .q(v405_s));
    ctsf_sync u_ilow (.clk(CLK), .rst(RST), .d(ISEN_BELOW_TERM), .q(ilow_s));
    ctsf_sync u_tok (.clk(CLK), .rst(RST), .d(TEMP_OK), .q(tok_s));
    ctsf_sync u_sc (.clk(CLK), .rst(RST), .d(SHORT_FAULT), .q(sc_s));

    wire to_hit = (to_cnt >= TO_CYC - 32'd1) && OSC_TICK;
    wire tr_hit = (to_cnt >= (TO_CYC >> `CTSF_TRICKLE_DIV) - 32'd1) && OSC_TICK;
    // the count alone is not enough: current and voltage must still qualify now
    wire eoc_ok = (eoc_cnt >= `CTSF_EOC_QUAL_CYC) && ilow_s && vrc_s;
    wire active = (state == CTSF_TRICKLE) || (state == CTSF_FAST) || (state == CTSF_TOPOFF);

    // charge sequencing; temperature only pauses, it never moves the state
    always_comb begin
        next_state = state;
        next_to_cnt = to_cnt;
        next_eoc_cnt = eoc_cnt;
        next_green = green;
        if (active && tok_s && OSC_TICK) begin
            next_to_cnt = to_cnt + 32'd1;
        end
        // low current only counts with voltage above the recharge level
        if (active && tok_s && OSC_TICK) begin
            next_eoc_cnt = (ilow_s && vrc_s) ? ((eoc_cnt == 3'h7) ? eoc_cnt : eoc_cnt + 3'h1) : 3'h0;
        end
        case (state)
            CTSF_LAMP_SEQ: begin
                if (lamp_step == 2'h3 && lamp_cnt >= LAMP_CLKS - 1) begin
                    next_state = CTSF_IDLE;
                end
            end
            CTSF_IDLE: begin
                if (en_s && tok_s) begin
                    next_state = CTSF_TRICKLE;
                    next_to_cnt = 32'h0;
                    next_eoc_cnt = 3'h0;
                end
            end
            CTSF_TRICKLE: begin
                if (sc_s) begin
                    next_state = CTSF_FAULT;
                end else if (tr_hit && !vtr_s) begin
                    next_state = CTSF_FAULT;
                end else if (vtr_s && to_cnt >= 32'(`CTSF_TRICKLE_MIN_CYC)) begin
                    next_state = CTSF_FAST;
                end
            end
            CTSF_FAST: begin
                if (eoc_ok) begin
                    next_state = CTSF_TOPOFF;
                    next_to_cnt = 32'h0;
                    next_green = 1'b1;
                end else if (to_hit) begin
                    next_green = 1'b1;
                    next_to_cnt = 32'h0;
                    next_state = v405_s ? CTSF_TOPOFF : CTSF_LATCH_OFF;
                end
            end
            CTSF_TOPOFF: begin
                if (to_hit) begin
                    next_state = CTSF_DONE_OFF;
                end
            end
            CTSF_DONE_OFF: begin
                if (!vrc_s) begin
                    next_state = CTSF_TRICKLE;
                    next_to_cnt = 32'h0;
                    next_eoc_cnt = 3'h0;
                end
            end
            CTSF_LATCH_OFF: begin
            end
            CTSF_FAULT: begin
                next_green = 1'b0;
            end
            default: begin
                next_state = CTSF_IDLE;
            end
        endcase
        // dropping enable leaves any state but the lamp sequence; latched ones clear only this way
        if (!en_s && state != CTSF_LAMP_SEQ) begin
            next_state = CTSF_IDLE;
            next_green = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= CTSF_LAMP_SEQ;
            to_cnt <= 32'h0;
            eoc_cnt <= 3'h0;
            green <= 1'b0;
        end else begin
            state <= next_state;
            to_cnt <= next_to_cnt;
            eoc_cnt <= next_eoc_cnt;
            green <= next_green;
        end
    end

    // power-up lamp sequence and 1Hz flash timebase
    always_comb begin
        next_lamp_step = lamp_step;
        next_lamp_cnt = lamp_cnt;
        if (state == CTSF_LAMP_SEQ) begin
            if (lamp_cnt >= LAMP_CLKS - 1) begin
                next_lamp_cnt = 32'h0;
                next_lamp_step = lamp_step + 2'h1;
            end else begin
                next_lamp_cnt = lamp_cnt + 32'd1;
            end
        end
        next_fl_cnt = fl_cnt + 32'd1;
        next_flash = flash;
        if (fl_cnt >= FLASH_CLKS - 1) begin
            next_fl_cnt = 32'h0;
            next_flash = ~flash;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lamp_step <= 2'h0;
            lamp_cnt <= 32'h0;
            fl_cnt <= 32'h0;
            flash <= 1'b0;
        end else begin
            lamp_step <= next_lamp_step;
            lamp_cnt <= next_lamp_cnt;
            fl_cnt <= next_fl_cnt;
            flash <= next_flash;
        end
    end

    // lamp decode: led on means sink pulled low
    always_comb begin
        chg_led = 1'b0;
        done_led = 1'b0;
        if (state == CTSF_LAMP_SEQ) begin
            chg_led = (lamp_step == 2'h0) || (lamp_step == 2'h2);
            done_led = (lamp_step == 2'h1) || (lamp_step == 2'h2);
        end else if (state == CTSF_FAULT) begin
            chg_led = flash;
            done_led = flash;
        end else if (active && !tok_s) begin
            chg_led = 1'b1;
            done_led = 1'b1;
        end else if (green) begin
            done_led = 1'b1;
        end else if (active) begin
            chg_led = 1'b1;
        end
    end

    // outputs; charger pauses during a temperature fault
    assign CHARGER_ON = active && tok_s;
    assign TRICKLE_MODE = (state == CTSF_TRICKLE);
    assign CHG_LAMP_SINK_O = 1'b0;
    assign CHG_LAMP_SINK_OE = chg_led;
    assign DONE_LAMP_SINK_O = 1'b0;
    assign DONE_LAMP_SINK_OE = done_led;

    AST_LATCH_HOLDS: assert property (@(posedge CLK) disable iff (RST)
        (state == CTSF_LATCH_OFF && en_s) |=> state == CTSF_LATCH_OFF)
        else $error("latched off state left while enabled");
    AST_LATCH_GREEN: assert property (@(posedge CLK) disable iff (RST)
        state == CTSF_LATCH_OFF |-> DONE_LAMP_SINK_OE && !CHARGER_ON)
        else $error("latched off state not green or charger on");
    AST_TRICKLE_MIN: assert property (@(posedge CLK) disable iff (RST)
        ($past(state) == CTSF_TRICKLE && state == CTSF_FAST) |-> $past(to_cnt) >= 32'(`CTSF_TRICKLE_MIN_CYC))
        else $error("trickle left too early");
    // top-off is entered only by a qualified end of charge or by expiry above 4.05V
    AST_EOC_QUAL: assert property (@(posedge CLK) disable iff (RST)
        ($past(state) == CTSF_FAST && state == CTSF_TOPOFF)
            |-> ($past(eoc_cnt) >= `CTSF_EOC_QUAL_CYC && $past(vrc_s) && $past(ilow_s))
                || ($past(to_hit) && $past(v405_s)))
        else $error("end of charge without qualification");
    AST_FAULT_FLASH: assert property (@(posedge CLK) disable iff (RST)
        state == CTSF_FAULT |-> (CHG_LAMP_SINK_OE == flash) && (DONE_LAMP_SINK_OE == flash) && !CHARGER_ON)
        else $error("fault lamp not flashing yellow");
    AST_RED_CHARGING: assert property (@(posedge CLK) disable iff (RST)
        (active && tok_s && !green) |-> CHG_LAMP_SINK_OE && !DONE_LAMP_SINK_OE)
        else $error("charging lamp not red");
    AST_TEMP_YELLOW: assert property (@(posedge CLK) disable iff (RST)
        (active && !tok_s) |-> CHG_LAMP_SINK_OE && DONE_LAMP_SINK_OE && !CHARGER_ON)
        else $error("temperature fault not steady yellow");
    AST_ENABLE_OFF: assert property (@(posedge CLK) disable iff (RST)
        (!en_s && state != CTSF_LAMP_SEQ) |=> !CHARGER_ON)
        else $error("charger on without enable");
    AST_GREEN_KEEP: assert property (@(posedge CLK) disable iff (RST)
        ($past(green) && en_s && $past(en_s) && state != CTSF_FAULT) |-> green)
        else $error("green dropped without fault");
endmodule : ctsf_top

// *** verif/ctsf_pack_lamp.sv ***
// partner model: battery pack enable strap and bi-colour lamp
// assumes open-drain lamp sinks; a released line is pulled up through its lamp
`timescale 1ns/100ps
module ctsf_pack_lamp (
    // pack side
    input wire logic pack_in,
    output logic en_n,
    // lamp pins
    input wire logic chg_o,
    input wire logic chg_oe,
    input wire logic done_o,
    input wire logic done_oe,
    output logic [1:0] colour
);
    logic chg_line;
    logic done_line;
    // no pack means the internal pull-up disables charging
    assign en_n = pack_in ? 1'b0 : 1'b1;
    // released sinks float high, so an unknown drive cannot pass as off
    assign chg_line = chg_oe ? chg_o : 1'b1;
    assign done_line = done_oe ? done_o : 1'b1;
    // a low line lights its colour: bit 1 red, bit 0 green
    assign colour = {~chg_line, ~done_line};
endmodule : ctsf_pack_lamp

// *** verif/charge_timer_status_fsm_tb.sv ***
// self-checking bench for the charge timer and status state machine
// assumes shortened timeout and lamp counts; one oscillator tick every fourth clock
`timescale 1ns/100ps
module charge_timer_status_fsm_tb;
    import ctsf_pkg::*;
    localparam logic [31:0] TO = 32'h00000100;
    localparam int LAMP = 20;
    localparam logic [1:0] OFF = 2'h0, GREEN = 2'h1, RED = 2'h2, YEL = 2'h3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic pack = 1'b0;
    logic v_trk = 1'b1;
    logic v_rch = 1'b0;
    logic v_405 = 1'b0;
    logic i_low = 1'b0;
    logic t_ok = 1'b1;
    logic s_flt = 1'b0;
    logic en_n, chg_on, trk_mode, chg_o, chg_oe, done_o, done_oe;
    logic [1:0] colour;
    logic [3:0] seen;
    int fails = 0;
    int tests_run = 0;
    ctsf_top #(.TO_CYC(TO), .LAMP_CLKS(LAMP), .FLASH_CLKS(LAMP)) uut (
        .CLK(clk), .RST(rst), .OSC_TICK(osc_tick), .EN_N(en_n),
        .VBAT_ABOVE_TRICKLE(v_trk), .VBAT_ABOVE_RECHG(v_rch), .VBAT_ABOVE_405(v_405),
        .ISEN_BELOW_TERM(i_low), .TEMP_OK(t_ok), .SHORT_FAULT(s_flt),
        .CHARGER_ON(chg_on), .TRICKLE_MODE(trk_mode), .CHG_LAMP_SINK_O(chg_o),
        .CHG_LAMP_SINK_OE(chg_oe), .DONE_LAMP_SINK_O(done_o), .DONE_LAMP_SINK_OE(done_oe));
    ctsf_pack_lamp pm (.pack_in(pack), .en_n(en_n), .chg_o(chg_o), .chg_oe(chg_oe),
        .done_o(done_o), .done_oe(done_oe), .colour(colour));
    always #2.5 clk = ~clk;
    // a tick every fourth clock keeps the timeout near a thousand clocks, not minutes
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        osc_tick <= (tick_cnt == 2'h3);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic ticks(input int n);
        cyc(4 * n);
    endtask : ticks
    task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // lifting the pack toggles enable, which clears latched states
    task automatic replug();
        @(posedge clk) pack <= 1'b0;
        ticks(4);
        @(posedge clk) pack <= 1'b1;
        ticks(3);
    endtask : replug
    task automatic t_lamp_seq();
        logic [1:0] seq [4];
        seq = '{RED, GREEN, YEL, OFF};
        check("reset lamp", RED, colour);
        @(posedge clk) rst <= 1'b0;
        cyc(LAMP / 2);
        for (int i = 0; i < 4; i++) begin
            check("lamp step", seq[i], colour);
            cyc(LAMP);
        end
        check("idle lamp", OFF, colour);
        check("idle charger", 2'h0, {1'b0, chg_on});
    endtask : t_lamp_seq
    task automatic t_charge_cycle();
        @(posedge clk) pack <= 1'b1;
        ticks(3);
        check("trickle", 2'h1, {1'b0, trk_mode});
        check("charging lamp", RED, colour);
        check("charging on", 2'h1, {1'b0, chg_on});
        ticks(8);
        check("trickle held", 2'h1, {1'b0, trk_mode});
        ticks(9);
        check("fast", 2'h0, {1'b0, trk_mode});
        @(posedge clk) i_low <= 1'b1;
        ticks(8);
        check("foldback lamp", RED, colour);
        @(posedge clk) v_rch <= 1'b1;
        ticks(1);
        check("eoc early", RED, colour);
        ticks(5);
        check("eoc lamp", GREEN, colour);
        check("topoff on", 2'h1, {1'b0, chg_on});
        ticks(270);
        check("done off", 2'h0, {1'b0, chg_on});
        check("done lamp", GREEN, colour);
        @(posedge clk) v_rch <= 1'b0;
        ticks(4);
        check("recharge on", 2'h1, {1'b0, chg_on});
        check("recharge lamp", GREEN, colour);
    endtask : t_charge_cycle
    task automatic t_temp_fault();
        @(posedge clk) t_ok <= 1'b0;
        ticks(2);
        check("temp lamp", YEL, colour);
        check("temp off", 2'h0, {1'b0, chg_on});
        cyc(3 * LAMP);
        check("temp steady", YEL, colour);
        @(posedge clk) t_ok <= 1'b1;
        ticks(2);
        check("temp cleared", 2'h1, {1'b0, chg_on});
    endtask : t_temp_fault
    task automatic t_trickle_timeout();
        @(posedge clk) v_trk <= 1'b0;
        replug();
        check("trickle restart", RED, colour);
        ticks(40);
        check("trickle fault", 2'h0, {1'b0, chg_on});
        seen = 4'h0;
        repeat (3 * LAMP) begin
            cyc(1);
            seen[colour] = 1'b1;
        end
        check("flash yellow", 2'h1, {1'b0, seen[3]});
        check("flash dark", 2'h1, {1'b0, seen[0]});
        check("flash pure", 2'h0, seen[2:1]);
        @(posedge clk) v_trk <= 1'b1;
        ticks(20);
        check("fault latched", 2'h0, {1'b0, chg_on});
    endtask : t_trickle_timeout
    task automatic t_timeout_paths();
        @(posedge clk) i_low <= 1'b0;
        @(posedge clk) v_405 <= 1'b1;
        @(posedge clk) v_rch <= 1'b1;
        replug();
        check("fault cleared", RED, colour);
        ticks(270);
        check("expiry lamp", GREEN, colour);
        check("expiry on", 2'h1, {1'b0, chg_on});
        @(posedge clk) v_405 <= 1'b0;
        @(posedge clk) v_rch <= 1'b0;
        replug();
        ticks(270);
        check("low expiry lamp", GREEN, colour);
        check("low expiry off", 2'h0, {1'b0, chg_on});
        ticks(20);
        check("latch held", 2'h0, {1'b0, chg_on});
        replug();
        check("latch left", RED, colour);
    endtask : t_timeout_paths
    // a short seen during trickle latches a flashing fault until the pack is lifted
    task automatic t_short_fault();
        @(posedge clk) s_flt <= 1'b1;
        ticks(2);
        check("short off", 2'h0, {1'b0, chg_on});
        check("short mode", 2'h0, {1'b0, trk_mode});
        @(posedge clk) s_flt <= 1'b0;
        ticks(4);
        check("short latched", 2'h0, {1'b0, chg_on});
        replug();
        check("short cleared", RED, colour);
    endtask : t_short_fault
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence after eleven clocks of reset
    initial begin
        cyc(11);
        t_lamp_seq();
        t_charge_cycle();
        t_temp_fault();
        t_trickle_timeout();
        t_timeout_paths();
        t_short_fault();
        print_verdict();
    end
    // the run needs about 4100 clocks; over three times that means a hang
    initial begin
        #75us;
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        print_verdict();
    end
endmodule : charge_timer_status_fsm_tb
